//--- pkg/dmag_defs.svh
`ifndef DMAG_DEFS_SVH
`define DMAG_DEFS_SVH

// channel space and sentinel values
`define DMAG_NCH        64
`define DMAG_LINK_NULL  16'hFFFF
`define DMAG_RST_FLAGS  64'h0000_0000_0000_0000
`define DMAG_RD_ZERO    32'h0000_0000
`define DMAG_QBIT       6

// byte offsets within the block's window (low eight address bits)
`define DMAG_EVT_LO     8'h00
`define DMAG_EVT_HI     8'h04
`define DMAG_EVTC_LO    8'h08
`define DMAG_EVTC_HI    8'h0C
`define DMAG_EEN_LO     8'h10
`define DMAG_EEN_HI     8'h14
`define DMAG_EENS_LO    8'h18
`define DMAG_EENS_HI    8'h1C
`define DMAG_EENC_LO    8'h20
`define DMAG_EENC_HI    8'h24
`define DMAG_SEC_LO     8'h28
`define DMAG_SEC_HI     8'h2C
`define DMAG_SECC_LO    8'h30
`define DMAG_SECC_HI    8'h34
`define DMAG_MIS_LO     8'h38
`define DMAG_MIS_HI     8'h3C
`define DMAG_MISC_LO    8'h40
`define DMAG_MISC_HI    8'h44
`define DMAG_IEN_LO     8'h48
`define DMAG_IEN_HI     8'h4C
`define DMAG_IENS_LO    8'h50
`define DMAG_IENS_HI    8'h54
`define DMAG_IENC_LO    8'h58
`define DMAG_IENC_HI    8'h5C
`define DMAG_PND_LO     8'h60
`define DMAG_PND_HI     8'h64
`define DMAG_PNDC_LO    8'h68
`define DMAG_PNDC_HI    8'h6C
`define DMAG_QEN        8'h70
`define DMAG_QENS       8'h74
`define DMAG_QENC       8'h78
`define DMAG_QSEC       8'h7C
`define DMAG_QSECC      8'h80
`define DMAG_QMIS       8'h84
`define DMAG_QMISC      8'h88
`define DMAG_RGN_BASE   8'h90
`define DMAG_RGN_STRIDE 8'h08
`define DMAG_NUL_LO     8'hB0
`define DMAG_NUL_HI     8'hB4
`define DMAG_LOAD_LO    8'hB8
`define DMAG_LOAD_HI    8'hBC
`define DMAG_QNUL       8'hC0
`define DMAG_QLOAD      8'hC4

`endif

//--- pkg/dmag_pkg.sv
package dmag_pkg;

    // service offer state, one-hot
    typedef enum logic [1:0] {
        DMAG_IDLE  = 2'b01,
        DMAG_OFFER = 2'b10
    } dmag_svc_t;

endpackage

//--- rtl/dmag_flags.sv
`timescale 1ns/1ps
`include "dmag_defs.svh"

// bank of sticky bits; a set in the same cycle as a clear wins
module dmag_flags
    import dmag_pkg::*;
#(
    parameter int W = 64
) (
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic [W-1:0] set_bits,
    input  wire logic [W-1:0] clr_bits,
    output logic      [W-1:0] q
);

    logic [W-1:0] q_next;

    assign q_next = (q & ~clr_bits) | set_bits;

    // reset state is all clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= W'(`DMAG_RST_FLAGS);
        end else begin
            q <= q_next;
        end
    end

endmodule

//--- rtl/dmag_irq.sv
`timescale 1ns/1ps
`include "dmag_defs.svh"

// one registered completion interrupt level per region
module dmag_irq
    import dmag_pkg::*;
#(
    parameter int NUM_RGN = 4
) (
    input  wire logic                        hclk,
    input  wire logic                        hresetn,
    input  wire logic [`DMAG_NCH-1:0]        pend,
    input  wire logic [`DMAG_NCH-1:0]        ien,
    input  wire logic [NUM_RGN*`DMAG_NCH-1:0] rgn_en,
    output logic      [NUM_RGN-1:0]          irq_reg
);

    logic [NUM_RGN-1:0] irq_next;

    // region enable acts as a second enable beside the interrupt mask;
    // overlapping region masks each raise their own line
    always_comb begin
        for (int r = 0; r < NUM_RGN; r++) begin
            irq_next[r] = |(pend & ien & rgn_en[r*`DMAG_NCH +: `DMAG_NCH]);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_reg <= '0;
        end else begin
            irq_reg <= irq_next;
        end
    end

endmodule

//--- rtl/dmag_top.sv
// The address map and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`include "dmag_defs.svh"

module dmag_top
    import dmag_pkg::*;
#(
    parameter int NUM_Q   = 8,
    parameter int NUM_RGN = 4
) (
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic                      hreadyout,
    output logic      [31:0]          hrdata,
    output logic                      hresp,
    input  wire logic [`DMAG_NCH-1:0] evt_pin,
    output logic                      svc_valid,
    output logic      [6:0]           svc_chan,
    input  wire logic                 svc_ready,
    input  wire logic                 done_valid,
    input  wire logic [6:0]           done_chan,
    input  wire logic                 done_static,
    input  wire logic [15:0]          done_link,
    input  wire logic                 cmp_valid,
    input  wire logic [5:0]           completion_code,
    input  wire logic                 cmp_final,
    input  wire logic                 final_done_irq_enable,
    input  wire logic                 partial_done_irq_enable,
    output logic      [NUM_RGN-1:0]   rgn_irq
);

    localparam int N = `DMAG_NCH;

    // lowest set bit wins; used for both channel kinds
    function automatic logic [5:0] first_set(input logic [N-1:0] v);
        logic [5:0] idx;
        idx = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = 6'(i);
            end
        end
        return idx;
    endfunction

    // software write-one word pair into a 64-bit mask
    function automatic logic [N-1:0] w64(input logic lo, input logic hi,
                                         input logic [31:0] d);
        return {(hi ? d : `DMAG_RD_ZERO), (lo ? d : `DMAG_RD_ZERO)};
    endfunction

    // ---------------- bus slave ----------------
    logic        ph_reg;
    logic        wr_reg;
    logic [7:0]  a_reg;
    logic        hreadyout_reg;
    logic [31:0] hrdata_reg;
    logic        hresp_reg;
    logic        acc;
    logic        wen;
    logic [31:0] rd_word;

    // only whole-word singles are expected; hsize is not checked
    assign acc = hsel & htrans[1] & hready;
    assign wen = ph_reg & wr_reg;

    // every transfer takes one wait state so read data leaves a flop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_reg        <= 1'b0;
            wr_reg        <= 1'b0;
            a_reg         <= '0;
            hreadyout_reg <= 1'b1;
            hrdata_reg    <= `DMAG_RD_ZERO;
            hresp_reg     <= 1'b0;
        end else begin
            ph_reg        <= acc;
            hreadyout_reg <= ~acc;
            hresp_reg     <= 1'b0;
            if (acc) begin
                wr_reg <= hwrite;
                a_reg  <= haddr[7:0];
            end
            if (ph_reg) begin
                hrdata_reg <= wr_reg ? `DMAG_RD_ZERO : rd_word;
            end
        end
    end

    assign hreadyout = hreadyout_reg;
    assign hrdata    = hrdata_reg;
    assign hresp     = hresp_reg;

    // write strobes, one per write-one register
    logic w_evtc_lo, w_evtc_hi, w_eens_lo, w_eens_hi, w_eenc_lo, w_eenc_hi;
    logic w_secc_lo, w_secc_hi, w_misc_lo, w_misc_hi;
    logic w_iens_lo, w_iens_hi, w_ienc_lo, w_ienc_hi, w_pndc_lo, w_pndc_hi;
    logic w_qens, w_qenc, w_qsecc, w_qmisc, w_load_lo, w_load_hi, w_qload;

    // set and clear only via write-one registers
    assign w_evtc_lo = wen & (a_reg == `DMAG_EVTC_LO);
    assign w_evtc_hi = wen & (a_reg == `DMAG_EVTC_HI);
    assign w_eens_lo = wen & (a_reg == `DMAG_EENS_LO);
    assign w_eens_hi = wen & (a_reg == `DMAG_EENS_HI);
    assign w_eenc_lo = wen & (a_reg == `DMAG_EENC_LO);
    assign w_eenc_hi = wen & (a_reg == `DMAG_EENC_HI);
    assign w_secc_lo = wen & (a_reg == `DMAG_SECC_LO);
    assign w_secc_hi = wen & (a_reg == `DMAG_SECC_HI);
    assign w_misc_lo = wen & (a_reg == `DMAG_MISC_LO);
    assign w_misc_hi = wen & (a_reg == `DMAG_MISC_HI);
    assign w_iens_lo = wen & (a_reg == `DMAG_IENS_LO);
    assign w_iens_hi = wen & (a_reg == `DMAG_IENS_HI);
    assign w_ienc_lo = wen & (a_reg == `DMAG_IENC_LO);
    assign w_ienc_hi = wen & (a_reg == `DMAG_IENC_HI);
    assign w_pndc_lo = wen & (a_reg == `DMAG_PNDC_LO);
    assign w_pndc_hi = wen & (a_reg == `DMAG_PNDC_HI);
    assign w_qens    = wen & (a_reg == `DMAG_QENS);
    assign w_qenc    = wen & (a_reg == `DMAG_QENC);
    assign w_qsecc   = wen & (a_reg == `DMAG_QSECC);
    assign w_qmisc   = wen & (a_reg == `DMAG_QMISC);
    assign w_load_lo = wen & (a_reg == `DMAG_LOAD_LO);
    assign w_load_hi = wen & (a_reg == `DMAG_LOAD_HI);
    assign w_qload   = wen & (a_reg == `DMAG_QLOAD);

    // ---------------- event pins ----------------
    logic [N-1:0] evt_s1_reg;
    logic [N-1:0] evt_s2_reg;
    logic [N-1:0] evt_s3_reg;
    logic [N-1:0] evt_rise;

    // two-flop synchroniser, edge taken past the second stage
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            evt_s1_reg <= `DMAG_RST_FLAGS;
            evt_s2_reg <= `DMAG_RST_FLAGS;
            evt_s3_reg <= `DMAG_RST_FLAGS;
        end else begin
            evt_s1_reg <= evt_pin;
            evt_s2_reg <= evt_s1_reg;
            evt_s3_reg <= evt_s2_reg;
        end
    end

    assign evt_rise = evt_s2_reg & ~evt_s3_reg;

    // ---------------- flag banks ----------------
    logic [N-1:0]     evt_q, een_q, sec_q, mis_q, ien_q, pnd_q, nul_q;
    logic [NUM_Q-1:0] qevt_q, qen_q, qsec_q, qmis_q, qnul_q;
    logic [N-1:0]     take_dma, err_dma, cmp_set, nul_dma;
    logic [NUM_Q-1:0] take_q, err_q, nul_qset, qload_bits;

    dmag_flags #(.W(N)) u_evt (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .set_bits (evt_rise),
        .clr_bits (w64(w_evtc_lo, w_evtc_hi, hwdata) | take_dma),
        .q        (evt_q)
    );

    dmag_flags #(.W(N)) u_een (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .set_bits (w64(w_eens_lo, w_eens_hi, hwdata)),
        .clr_bits (w64(w_eenc_lo, w_eenc_hi, hwdata)),
        .q        (een_q)
    );

    dmag_flags #(.W(N)) u_sec (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .set_bits (err_dma),
        .clr_bits (w64(w_secc_lo, w_secc_hi, hwdata)),
        .q        (sec_q)
    );

    dmag_flags #(.W(N)) u_mis (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .set_bits (err_dma),
        .clr_bits (w64(w_misc_lo, w_misc_hi, hwdata)),
        .q        (mis_q)
    );

    dmag_flags #(.W(N)) u_ien (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .set_bits (w64(w_iens_lo, w_iens_hi, hwdata)),
        .clr_bits (w64(w_ienc_lo, w_ienc_hi, hwdata)),
        .q        (ien_q)
    );

    // pending stays until the handler clears it
    dmag_flags #(.W(N)) u_pnd (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .set_bits (cmp_set),
        .clr_bits (w64(w_pndc_lo, w_pndc_hi, hwdata)),
        .q        (pnd_q)
    );

    // a load from software marks the descriptor set valid again
    dmag_flags #(.W(N)) u_nul (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .set_bits (nul_dma),
        .clr_bits (w64(w_load_lo, w_load_hi, hwdata)),
        .q        (nul_q)
    );

    assign qload_bits = w_qload ? hwdata[NUM_Q-1:0] : '0;

    // any quick descriptor update is a trigger
    dmag_flags #(.W(NUM_Q)) u_qevt (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .set_bits (qload_bits | nul_qset),
        .clr_bits (take_q),
        .q        (qevt_q)
    );

    dmag_flags #(.W(NUM_Q)) u_qen (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .set_bits (w_qens ? hwdata[NUM_Q-1:0] : '0),
        .clr_bits (w_qenc ? hwdata[NUM_Q-1:0] : '0),
        .q        (qen_q)
    );

    dmag_flags #(.W(NUM_Q)) u_qsec (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .set_bits (err_q),
        .clr_bits (w_qsecc ? hwdata[NUM_Q-1:0] : '0),
        .q        (qsec_q)
    );

    dmag_flags #(.W(NUM_Q)) u_qmis (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .set_bits (err_q),
        .clr_bits (w_qmisc ? hwdata[NUM_Q-1:0] : '0),
        .q        (qmis_q)
    );

    dmag_flags #(.W(NUM_Q)) u_qnul (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .set_bits (nul_qset),
        .clr_bits (qload_bits),
        .q        (qnul_q)
    );

    // ---------------- link end and completion ----------------
    logic link_end;

    // last submission of a linked-to-null set
    assign link_end = done_valid & ~done_static & (done_link == `DMAG_LINK_NULL);
    assign nul_dma  = (link_end & ~done_chan[`DMAG_QBIT]) ?
                      (N'(1) << done_chan[5:0]) : '0;
    // null reload on a quick channel triggers it too
    assign nul_qset = (link_end & done_chan[`DMAG_QBIT]) ?
                      (NUM_Q'(1) << done_chan[2:0]) : '0;

    // only enabled completions pend; indexed by code
    assign cmp_set = (cmp_valid & (cmp_final ? final_done_irq_enable
                                             : partial_done_irq_enable)) ?
                     (N'(1) << completion_code) : '0;

    // ---------------- service selection ----------------
    dmag_svc_t    st_reg;
    dmag_svc_t    st_next;
    logic [N-1:0] cand_dma;
    logic [N-1:0] cand_q;
    logic         any_dma;
    logic         any_q;
    logic         pick;
    logic [5:0]   pick_idx;
    logic         pick_null;
    logic         svc_valid_reg;
    logic [6:0]   svc_chan_reg;

    // event enable gate; secondary flag blocks
    assign cand_dma = evt_q & een_q & ~sec_q;
    // quick enable gate; quick secondary blocks
    assign cand_q   = N'(qevt_q & qen_q & ~qsec_q);
    assign any_dma  = |cand_dma;
    assign any_q    = |cand_q;

    // peripheral channels take precedence over quick channels
    assign pick      = (st_reg == DMAG_IDLE) & (any_dma | any_q);
    assign pick_idx  = any_dma ? first_set(cand_dma) : first_set(cand_q);
    assign pick_null = any_dma ? nul_q[pick_idx] : qnul_q[pick_idx[2:0]];

    assign take_dma = (pick & any_dma) ? (N'(1) << pick_idx) : '0;
    assign take_q   = (pick & ~any_dma) ? (NUM_Q'(1) << pick_idx[2:0]) : '0;
    // trigger on a null set is an error, never offered
    assign err_dma  = pick_null ? take_dma : '0;
    assign err_q    = pick_null ? take_q : '0;

    // offer held until the transfer controller takes it
    always_comb begin
        case (st_reg)
            DMAG_IDLE:  st_next = (pick & ~pick_null) ? DMAG_OFFER : DMAG_IDLE;
            DMAG_OFFER: st_next = svc_ready ? DMAG_IDLE : DMAG_OFFER;
            default:    st_next = DMAG_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_reg        <= DMAG_IDLE;
            svc_valid_reg <= 1'b0;
            svc_chan_reg  <= '0;
        end else begin
            st_reg        <= st_next;
            svc_valid_reg <= (st_next == DMAG_OFFER);
            if (pick & ~pick_null) begin
                svc_chan_reg <= {~any_dma, pick_idx};
            end
        end
    end

    assign svc_valid = svc_valid_reg;
    assign svc_chan  = svc_chan_reg;

    // ---------------- region enables and interrupts ----------------
    logic [N-1:0]           rgn_en_reg [NUM_RGN];
    logic [NUM_RGN*N-1:0]   rgn_flat;
    logic [NUM_RGN-1:0][31:0] rgn_rd;
    logic [31:0]            rgn_rd_any;

    for (genvar r = 0; r < NUM_RGN; r++) begin : g_rgn
        logic sel_lo;
        logic sel_hi;
        assign sel_lo = a_reg == 8'(`DMAG_RGN_BASE + r * `DMAG_RGN_STRIDE);
        assign sel_hi = a_reg == 8'(`DMAG_RGN_BASE + r * `DMAG_RGN_STRIDE + 4);
        assign rgn_flat[r*N +: N] = rgn_en_reg[r];
        assign rgn_rd[r] = sel_lo ? rgn_en_reg[r][31:0] :
                           sel_hi ? rgn_en_reg[r][63:32] : `DMAG_RD_ZERO;

        // plain read-write region masks
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                rgn_en_reg[r] <= `DMAG_RST_FLAGS;
            end else if (wen & sel_lo) begin
                rgn_en_reg[r][31:0] <= hwdata;
            end else if (wen & sel_hi) begin
                rgn_en_reg[r][63:32] <= hwdata;
            end
        end
    end

    always_comb begin
        rgn_rd_any = `DMAG_RD_ZERO;
        for (int r = 0; r < NUM_RGN; r++) begin
            rgn_rd_any = rgn_rd_any | rgn_rd[r];
        end
    end

    // gated by mask and region enable, level per region
    dmag_irq #(.NUM_RGN(NUM_RGN)) u_irq (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pend    (pnd_q),
        .ien     (ien_q),
        .rgn_en  (rgn_flat),
        .irq_reg (rgn_irq)
    );

    // ---------------- read data ----------------
    // write-only and unmapped offsets read zero
    assign rd_word =
        (a_reg == `DMAG_EVT_LO) ? evt_q[31:0]  :
        (a_reg == `DMAG_EVT_HI) ? evt_q[63:32] :
        (a_reg == `DMAG_EEN_LO) ? een_q[31:0]  :
        (a_reg == `DMAG_EEN_HI) ? een_q[63:32] :
        (a_reg == `DMAG_SEC_LO) ? sec_q[31:0]  :
        (a_reg == `DMAG_SEC_HI) ? sec_q[63:32] :
        (a_reg == `DMAG_MIS_LO) ? mis_q[31:0]  :
        (a_reg == `DMAG_MIS_HI) ? mis_q[63:32] :
        (a_reg == `DMAG_IEN_LO) ? ien_q[31:0]  :
        (a_reg == `DMAG_IEN_HI) ? ien_q[63:32] :
        (a_reg == `DMAG_PND_LO) ? pnd_q[31:0]  :
        (a_reg == `DMAG_PND_HI) ? pnd_q[63:32] :
        (a_reg == `DMAG_NUL_LO) ? nul_q[31:0]  :
        (a_reg == `DMAG_NUL_HI) ? nul_q[63:32] :
        (a_reg == `DMAG_QEN)    ? 32'(qen_q)   :
        (a_reg == `DMAG_QSEC)   ? 32'(qsec_q)  :
        (a_reg == `DMAG_QMIS)   ? 32'(qmis_q)  :
        (a_reg == `DMAG_QNUL)   ? 32'(qnul_q)  :
        rgn_rd_any;

endmodule

//--- verification/dmag_top_asserts.sv
`timescale 1ns/1ps
// port-level checker
module dmag_top_checker
    import dmag_pkg::*;
#(
    parameter int NUM_RGN = 4
) (
    input wire logic               hclk,
    input wire logic               hresetn,
    input wire logic               hsel,
    input wire logic [1:0]         htrans,
    input wire logic               hwrite,
    input wire logic               hready,
    input wire logic               hreadyout,
    input wire logic               hresp,
    input wire logic               svc_valid,
    input wire logic [6:0]         svc_chan,
    input wire logic               svc_ready,
    input wire logic               cmp_valid,
    input wire logic               cmp_final,
    input wire logic               final_done_irq_enable,
    input wire logic               partial_done_irq_enable,
    input wire logic [NUM_RGN-1:0] rgn_irq
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // accepted bus phases, enabled completions
    wire bus_req = hsel & htrans[1] & hready;
    wire bus_wr  = bus_req & hwrite;
    wire cmp_ok  = cmp_valid & (cmp_final ? final_done_irq_enable : partial_done_irq_enable);

    offer_hold_a: assert property (svc_valid && !svc_ready |=> svc_valid && $stable(svc_chan))
        else $error("offer not held");
    offer_once_a: assert property (svc_valid && svc_ready |=> !svc_valid)
        else $error("offer outlived acceptance");
    quick_index_a: assert property (svc_valid && svc_chan[6] |-> svc_chan[5:3] == 3'h0)
        else $error("quick offer out of range");
    bus_wait_a: assert property (bus_req |=> !hreadyout ##1 hreadyout)
        else $error("bus wait not one cycle");
    resp_okay_a: assert property (hresp == 1'b0)
        else $error("bus response not okay");
    irq_cause_a: assert property ($rose(|rgn_irq) |-> $past(cmp_ok, 2) || $past(bus_wr, 3))
        else $error("irq rose without cause");
    irq_change_a: assert property ($changed(rgn_irq) |-> $past(cmp_valid, 2) || $past(bus_wr, 3))
        else $error("irq changed without cause");
    irq_level_a: assert property ($fell(|rgn_irq) |-> $past(bus_wr, 3))
        else $error("irq fell without write");

    // main scenarios reached
    cover property (svc_valid && svc_ready);
    cover property ($rose(rgn_irq[0]));
    cover property (bus_req && !hwrite);
endmodule

bind dmag_top dmag_top_checker #(.NUM_RGN(NUM_RGN)) chk (
    .hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp, .svc_valid,
    .svc_chan, .svc_ready, .cmp_valid, .cmp_final, .final_done_irq_enable,
    .partial_done_irq_enable, .rgn_irq
);

//--- verification/dmag_tc_model.sv
`timescale 1ns/1ps
// transfer controller stand-in, fast or slow
module dmag_tc_model (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       svc_valid,
    input  wire logic [6:0] svc_chan,
    input  wire logic       slow,
    output logic            svc_ready,
    output logic      [6:0] last_chan,
    output int unsigned     cnt
);
    logic [1:0] dly;

    // slow mode stalls offers for up to three cycles
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            svc_ready <= 1'b0;
            dly       <= 2'h0;
            cnt       <= 0;
            last_chan <= 7'h00;
        end else begin
            if (svc_valid && svc_ready) begin
                cnt       <= cnt + 1;
                last_chan <= svc_chan;
            end
            dly       <= dly + 2'h1;
            svc_ready <= !slow || dly == 2'h3;
        end
    end
endmodule

//--- verification/tb_dma_event_and_completion_gating.sv
`timescale 1ns/1ps
`include "dmag_defs.svh"
module tb_dma_event_and_completion_gating
    import dmag_pkg::*;
;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, slow = 1'b0;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, rd, hrdata, r;
    logic [1:0]  htrans = 2'h0;
    logic [63:0] evt_pin = 64'h0000_0000_0000_0000;
    logic [6:0]  done_chan = 7'h00, svc_chan, last_chan;
    logic [15:0] done_link = 16'h0000;
    logic [5:0]  completion_code = 6'h00, c;
    logic [3:0]  rgn_irq, rm;
    logic        done_valid = 1'b0, done_static = 1'b0, cmp_valid = 1'b0, cmp_final = 1'b0;
    logic        fen = 1'b0, pen = 1'b0, hreadyout, hresp, svc_valid, svc_ready, ie;
    int unsigned cnt;
    int          fails = 0, compares = 0, cycles = 0;
    logic [31:0] seed = 32'h0000_0033;

    dmag_top #(.NUM_Q(8), .NUM_RGN(4)) dut (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hreadyout, .hrdata, .hresp, .evt_pin, .svc_valid, .svc_chan,
        .svc_ready, .done_valid, .done_chan, .done_static, .done_link, .cmp_valid,
        .completion_code, .cmp_final, .final_done_irq_enable(fen),
        .partial_done_irq_enable(pen), .rgn_irq);
    dmag_tc_model tc (.hclk, .hresetn, .svc_valid, .svc_chan, .slow, .svc_ready,
        .last_chan, .cnt);

    // clock and hang guard
    always #20 hclk = ~hclk;
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            $display("Error run time expected finish seen hang");
            give_verdict;
        end
    end

    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // selected descriptor enable gates irqs
    function logic [3:0] exp_irq(input logic [3:0] m, input logic e, f, fe, pe);
        return ((f ? fe : pe) && e) ? m : 4'h0;
    endfunction
    task check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // single word transfer, entered after an edge
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= {24'h00_0000, a};
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    // high mask word is four bytes up
    task wbit(input logic [7:0] lo, input int b);
        bus(1'b1, lo + ((b >= 32) ? 8'h04 : 8'h00), 32'h0000_0001 << b[4:0]);
    endtask
    task rbit(input string w, input logic [7:0] lo, input int b, input logic e);
        bus(1'b0, lo + ((b >= 32) ? 8'h04 : 8'h00), 32'h0000_0000);
        check(w, rd[b % 32], e);
    endtask
    task pulse(input int k);
        evt_pin[k] <= 1'b1;
        repeat (3) @(posedge hclk);
        evt_pin[k] <= 1'b0;
        repeat (2) @(posedge hclk);
    endtask
    task offers(input int unsigned n);
        for (int i = 0; i < 24 && cnt != n; i++) @(posedge hclk);
        check("offers taken", cnt, n);
    endtask
    task done(input logic [6:0] ch, input logic st, input logic [15:0] lk);
        done_chan   <= ch;
        done_static <= st;
        done_link   <= lk;
        done_valid  <= 1'b1;
        @(posedge hclk);
        done_valid <= 1'b0;
        @(posedge hclk);
    endtask
    task give_verdict;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        check("idle irq", rgn_irq, 4'h0);
        bus(1'b0, `DMAG_EEN_LO, 32'h0000_0000);
        check("enable mask", rd, 32'h0000_0000);
        $display("test reset done");
        // event waits for enable; masks set only via set register
        slow <= 1'(rnd());
        pulse(5);
        offers(0);
        rbit("event flag", `DMAG_EVT_LO, 5, 1'b1);
        bus(1'b1, `DMAG_EEN_LO, 32'hFFFF_FFFF);
        rbit("enable direct", `DMAG_EEN_LO, 5, 1'b0);
        pulse(6);
        wbit(`DMAG_EVTC_LO, 6);
        rbit("event clear", `DMAG_EVT_LO, 6, 1'b0);
        wbit(`DMAG_EENS_LO, 6);
        wbit(`DMAG_EENS_LO, 5);
        offers(1);
        check("offer chan", last_chan, 7'h05);
        $display("test enable done");
        // null set on a high channel, error and recovery
        slow <= ~slow;
        done(7'h28, 1'b0, `DMAG_LINK_NULL);
        done(7'h29, 1'b1, `DMAG_LINK_NULL);
        done(7'h2A, 1'b0, 16'h0040);
        bus(1'b0, `DMAG_NUL_HI, 32'h0000_0000);
        check("null sets", rd, 32'h0000_0100);
        wbit(`DMAG_EENS_LO, 40);
        pulse(40);
        offers(1);
        rbit("secondary", `DMAG_SEC_LO, 40, 1'b1);
        rbit("missed", `DMAG_MIS_LO, 40, 1'b1);
        pulse(40);
        offers(1);
        wbit(`DMAG_EVTC_LO, 40);
        wbit(`DMAG_SECC_LO, 40);
        wbit(`DMAG_MISC_LO, 40);
        wbit(`DMAG_LOAD_LO, 40);
        pulse(40);
        offers(2);
        check("offer chan", last_chan, 7'h28);
        $display("test null set done");
        // quick: load triggers, disabled idle, null reload errors
        wbit(`DMAG_QENS, 2);
        wbit(`DMAG_QLOAD, 2);
        offers(3);
        check("quick chan", last_chan, 7'h42);
        wbit(`DMAG_QLOAD, 3);
        offers(3);
        done(7'h42, 1'b0, `DMAG_LINK_NULL);
        offers(3);
        rbit("quick secondary", `DMAG_QSEC, 2, 1'b1);
        rbit("quick missed", `DMAG_QMIS, 2, 1'b1);
        $display("test quick done");
        // completions: code-indexed, two enables, regions
        for (int i = 0; i < 10; i++) begin
            r  = rnd();
            c  = (i == 0) ? 6'h3F : r[5:0];
            rm = r[9:6];
            ie = (i == 0) | r[10];
            if (ie) wbit(`DMAG_IENS_LO, c);
            for (int g = 0; g < 4; g++)
                bus(1'b1, 8'(`DMAG_RGN_BASE + 8 * g + ((c >= 32) ? 4 : 0)),
                    rm[g] ? 32'h0000_0001 << c[4:0] : 32'h0000_0000);
            completion_code <= c;
            cmp_final       <= r[11];
            fen             <= r[12] | (i == 0);
            pen             <= r[13];
            cmp_valid       <= 1'b1;
            @(posedge hclk);
            cmp_valid <= 1'b0;
            repeat (2) @(posedge hclk);
            check("region irq", rgn_irq, exp_irq(rm, ie, cmp_final, fen, pen));
            rbit("pending", `DMAG_PND_LO, c, cmp_final ? fen : pen);
            check("irq level", rgn_irq, exp_irq(rm, ie, cmp_final, fen, pen));
            wbit(`DMAG_PNDC_LO, c);
            wbit(`DMAG_IENC_LO, c);
            repeat (2) @(posedge hclk);
            check("irq cleared", rgn_irq, 4'h0);
        end
        $display("test completion done");
        give_verdict;
    end
endmodule
